// file: core/icache_diag_regs.svh
`ifndef ICACHE_DIAG_REGS_SVH
`define ICACHE_DIAG_REGS_SVH

// Addresses of the diagnostic registers in the core's CSR space.
`define ICD_CSR_ADDR_W 12
`define ICD_CSR_SELECT 12'h7C8
`define ICD_CSR_DATA 12'h7C9
`define ICD_CSR_CHECK 12'h7CA
`define ICD_CSR_GO 12'h7CB

// Field positions of the location select register.
`define ICD_SEL_ARRAY_BIT 24
`define ICD_SEL_WAY_HI 21
`define ICD_SEL_WAY_LO 20
`define ICD_SEL_IDX_HI 15
`define ICD_SEL_IDX_LO 2

// Field positions of the data word in tag mode.
`define ICD_TAG_HI 31
`define ICD_TAG_LO 12
`define ICD_LRU_HI 6
`define ICD_LRU_LO 4
`define ICD_VALID_BIT 0

// Trigger register go bit.
`define ICD_GO_BIT 0

// Reset values.
`define ICD_DATA_RESET 32'h0000_0000
`define ICD_CHECK_RESET 2'h0

// Geometry: four ways of sixty-four lines, sixteen chunks per line.
`define ICD_WAYS 4
`define ICD_SETS 64
`define ICD_LINES 256
`define ICD_IDX_W 14
`define ICD_DATA_ADDR_W 12
`define ICD_TAG_ADDR_W 8
`define ICD_TAG_W 20
`define ICD_CHECK_W 2
`define ICD_HALF_W 16

`endif

// file: core/icache_diag_pkg.sv
package icache_diag_pkg;

  // Access sequencer states, one-hot.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_LOAD = 2'b10
  } diag_state_type;

  // Complete register state of the diagnostic block.
  typedef struct packed {
    diag_state_type state;
    logic sel_array;
    logic [1:0] sel_way;
    logic [13:0] sel_index;
    logic [31:0] data_word;
    logic [1:0] check_bits;
    logic [255:0] line_valid;
    logic [63:0][2:0] set_lru;
    logic ack;
    logic illegal;
    logic [31:0] rdata;
    logic check_error;
  } diag_regs_type;

endpackage : icache_diag_pkg

// file: core/icache_diag_mem.sv
`timescale 1ns/100ps

module icache_diag_mem #(
  parameter int WIDTH = 34,
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk_i,
  input wire logic en_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem_q [0:(1<<ADDR_W)-1];

  // Single-port array; read data are registered, so they appear one edge after the request.
  // Contents are not reset, like the real SRAM, so software must fill it before trusting it.
  always_ff @(posedge ref_clk_i) begin
    if (en_i && we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    if (en_i && !we_i) begin
      rdata_o <= mem_q[addr_i];
    end
  end

endmodule : icache_diag_mem

// file: core/icache_diag_select_data.sv
`timescale 1ns/100ps
`include "icache_diag_regs.svh"

// Notes on behaviour
// - Array select bit: data or tag/status.
// - Two-bit way field picks the way.
// - Index right-justified, upper unused bits zero.
// - Tag access ignores chunk-select index bits.
// - Index field stores written value unchanged.
// - Access outside Debug Mode raises illegal.
// - Line is 64 bytes, sixteen chunk pairs.
// - Chunk pair: two halves, own check bits.
// - Four ways, four 16-byte banks each.
// - Index bits five, four select bank.
// - Index bits three, two select chunk.
// - Data mode: 32-bit chunk, halves checked separately.
// - Tag mode: tag right-justified in upper field.
// - LRU bits shared by whole set.
// - LRU encoding: pair, way0/1, way2/3 bits.
// - Tag mode bit zero is line valid.
// - Data word layout follows array select.
// - Software supplies check bits on writes.
// - Data registers hold values; trigger accesses.
// - Trigger read loads, go write stores.
// - Even parity per half; low covers tag.
// - Reserved bits read as zero; the data word reads back tag-mode reserved bits as written.
module icache_diag_select_data (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic csr_rd_en_i,
  input wire logic csr_wr_en_i,
  input wire logic [`ICD_CSR_ADDR_W-1:0] csr_addr_i,
  input wire logic [31:0] csr_wdata_i,
  input wire logic debug_mode_i,
  output logic csr_ready_o,
  output logic csr_ack_o,
  output logic [31:0] csr_rdata_o,
  output logic csr_illegal_o,
  output logic check_error_o
);

  import icache_diag_pkg::*;

  diag_regs_type r_q;
  diag_regs_type r_d;

  // Request decode signals.
  logic hit_select;
  logic hit_data;
  logic hit_check;
  logic hit_go;
  logic hit_any;
  logic req_taken;
  logic req_allowed;
  logic do_write;
  logic do_read;
  logic go_write;
  logic go_read;

  // Location derived from the select register.
  logic [5:0] line_set;
  logic [7:0] line_slot;
  logic [1:0] bank_sel;
  logic [1:0] chunk_sel;
  logic [`ICD_DATA_ADDR_W-1:0] data_addr;
  logic [`ICD_TAG_ADDR_W-1:0] tag_addr;

  // Array ports.
  logic data_en;
  logic data_we;
  logic [33:0] data_wdata;
  logic [33:0] data_rdata;
  logic tag_en;
  logic tag_we;
  logic [20:0] tag_wdata;
  logic [20:0] tag_rdata;

  // Even parity over each half of the fetched chunk.
  logic [`ICD_CHECK_W-1:0] half_parity;
  logic tag_parity;

  // Register read values with reserved bits forced to zero.
  logic [31:0] select_view;
  logic [31:0] check_view;
  logic [31:0] tag_view;

  // The sequencer only refuses requests while a trigger read is being folded into the
  // data registers; that keeps a fast follow-up read from seeing stale contents.
  assign csr_ready_o = (r_q.state == ST_IDLE);
  assign csr_ack_o = r_q.ack;
  assign csr_rdata_o = r_q.rdata;
  assign csr_illegal_o = r_q.illegal;
  assign check_error_o = r_q.check_error;

  // Address decode for the four diagnostic CSRs; other addresses belong to other blocks.
  assign hit_select = (csr_addr_i == `ICD_CSR_SELECT);
  assign hit_data = (csr_addr_i == `ICD_CSR_DATA);
  assign hit_check = (csr_addr_i == `ICD_CSR_CHECK);
  assign hit_go = (csr_addr_i == `ICD_CSR_GO);
  assign hit_any = hit_select | hit_data | hit_check | hit_go;
  assign req_taken = (csr_rd_en_i | csr_wr_en_i) & csr_ready_o & hit_any;
  assign req_allowed = req_taken & debug_mode_i;
  assign do_write = req_allowed & csr_wr_en_i;
  assign do_read = req_allowed & csr_rd_en_i;

  // A go write that also reads gives the write priority; the read part returns zero only.
  assign go_write = do_write & hit_go & csr_wdata_i[`ICD_GO_BIT];
  assign go_read = do_read & hit_go & ~go_write;

  // Index layout: stored bits [9:4] pick the line, [3:2] the bank, [1:0] the chunk.
  // Stored bits [13:10] address no line in this cache size and are ignored here.
  assign line_set = r_q.sel_index[9:4];
  assign bank_sel = r_q.sel_index[3:2];
  assign chunk_sel = r_q.sel_index[1:0];
  assign line_slot = {r_q.sel_way, line_set};
  assign data_addr = {r_q.sel_way, line_set, bank_sel, chunk_sel};
  assign tag_addr = {r_q.sel_way, line_set};

  // Array strobes; the array select steers every access to exactly one array.
  assign data_en = (go_write | go_read) & ~r_q.sel_array;
  assign data_we = go_write;
  assign tag_en = (go_write | go_read) & r_q.sel_array;
  assign tag_we = go_write;

  // Check bits are taken from software as they stand, so errors can be injected.
  assign data_wdata = {r_q.check_bits, r_q.data_word};
  assign tag_wdata = {r_q.check_bits[0], r_q.data_word[`ICD_TAG_HI:`ICD_TAG_LO]};

  // Parity per 16-bit half of the chunk read back from the data array.
  genvar g;
  generate
    for (g = 0; g < `ICD_CHECK_W; g = g + 1) begin : g_half
      assign half_parity[g] = ^data_rdata[g*`ICD_HALF_W +: `ICD_HALF_W];
    end
  endgenerate
  assign tag_parity = ^tag_rdata[`ICD_TAG_W-1:0];

  // Read view of the select register; reserved fields are hardwired to zero.
  assign select_view = {7'h00, r_q.sel_array, 2'h0, r_q.sel_way, 4'h0,
                        r_q.sel_index, 2'h0};
  assign check_view = {30'h0000_0000, r_q.check_bits};

  // Tag-mode image of the selected line: tag, shared set LRU and the line's valid bit.
  assign tag_view = {tag_rdata[`ICD_TAG_W-1:0], 5'h00, r_q.set_lru[line_set], 3'h0,
                     r_q.line_valid[line_slot]};

  // Next-state logic for the whole block.
  always_comb begin
    r_d = r_q;
    r_d.ack = 1'b0;
    r_d.illegal = 1'b0;

    // Answer every taken request one edge later; outside Debug Mode only illegal is raised.
    if (req_taken) begin
      r_d.ack = 1'b1;
      r_d.illegal = ~debug_mode_i;
      r_d.rdata = 32'h0000_0000;
    end

    // Read data of the addressed register; the go bit always reads as zero.
    if (do_read) begin
      if (hit_select) begin
        r_d.rdata = select_view;
      end else if (hit_data) begin
        r_d.rdata = r_q.data_word;
      end else if (hit_check) begin
        r_d.rdata = check_view;
      end else begin
        r_d.rdata = 32'h0000_0000;
      end
    end

    // Software writes. The index is stored without legalising, like the other fields,
    // and the selection changes only through this path.
    if (do_write && hit_select) begin
      r_d.sel_array = csr_wdata_i[`ICD_SEL_ARRAY_BIT];
      r_d.sel_way = csr_wdata_i[`ICD_SEL_WAY_HI:`ICD_SEL_WAY_LO];
      r_d.sel_index = csr_wdata_i[`ICD_SEL_IDX_HI:`ICD_SEL_IDX_LO];
    end
    // The data word is fully writable in both layouts, unused tag-mode bits included.
    if (do_write && hit_data) begin
      r_d.data_word = csr_wdata_i;
    end
    if (do_write && hit_check) begin
      r_d.check_bits = csr_wdata_i[`ICD_CHECK_W-1:0];
    end

    // A go write into the tag side also updates the status flops of the line and set.
    if (go_write && r_q.sel_array) begin
      r_d.line_valid[line_slot] = r_q.data_word[`ICD_VALID_BIT];
      r_d.set_lru[line_set] = r_q.data_word[`ICD_LRU_HI:`ICD_LRU_LO];
    end

    // Sequencer: a trigger read waits one edge for the registered array output.
    case (r_q.state)
      ST_IDLE: begin
        if (go_read) begin
          r_d.state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        r_d.state = ST_IDLE;
        if (!r_q.sel_array) begin
          // Upper half pairs with the high check bit, lower half with the low one.
          r_d.data_word = data_rdata[31:0];
          r_d.check_bits = data_rdata[33:32];
          r_d.check_error = |(half_parity ^ data_rdata[33:32]);
        end else begin
          r_d.data_word = tag_view;
          r_d.check_bits = {1'b0, tag_rdata[`ICD_TAG_W]};
          r_d.check_error = tag_parity ^ tag_rdata[`ICD_TAG_W];
        end
      end
      default: begin
        r_d.state = ST_IDLE;
      end
    endcase
  end

  // State register; every field but the state, which goes to ST_IDLE, clears on reset, so the cache reads as all lines invalid.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      r_q.state <= ST_IDLE;
      r_q.sel_array <= 1'b0;
      r_q.sel_way <= 2'h0;
      r_q.sel_index <= 14'h0000;
      r_q.data_word <= `ICD_DATA_RESET;
      r_q.check_bits <= `ICD_CHECK_RESET;
      r_q.line_valid <= '0;
      r_q.set_lru <= '0;
      r_q.ack <= 1'b0;
      r_q.illegal <= 1'b0;
      r_q.rdata <= 32'h0000_0000;
      r_q.check_error <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  // Instruction data array: 34-bit words of chunk plus its two check bits.
  icache_diag_mem #(
    .WIDTH(34),
    .ADDR_W(`ICD_DATA_ADDR_W)
  ) u_data_array (
    .ref_clk_i(ref_clk_i),
    .en_i(data_en),
    .we_i(data_we),
    .addr_i(data_addr),
    .wdata_i(data_wdata),
    .rdata_o(data_rdata)
  );

  // Tag array: one entry per way and line, so chunk bits of the index play no part.
  icache_diag_mem #(
    .WIDTH(21),
    .ADDR_W(`ICD_TAG_ADDR_W)
  ) u_tag_array (
    .ref_clk_i(ref_clk_i),
    .en_i(tag_en),
    .we_i(tag_we),
    .addr_i(tag_addr),
    .wdata_i(tag_wdata),
    .rdata_o(tag_rdata)
  );

endmodule : icache_diag_select_data

// file: verif/icache_diag_checker.sv
`timescale 1ns/100ps

// Port-level timing and reserved-bit checks for the diagnostic block.
module icache_diag_checker (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic csr_rd_en_i,
  input wire logic csr_wr_en_i,
  input wire logic [11:0] csr_addr_i,
  input wire logic [31:0] csr_wdata_i,
  input wire logic debug_mode_i,
  input wire logic csr_ready_o,
  input wire logic csr_ack_o,
  input wire logic [31:0] csr_rdata_o,
  input wire logic csr_illegal_o,
  input wire logic check_error_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic take;
  logic rd_go;
  // A request counts only with ready high and one of the four addresses.
  assign take = (csr_rd_en_i | csr_wr_en_i) & csr_ready_o & (csr_addr_i[11:2] == 10'h1F2);
  assign rd_go = take & csr_rd_en_i & ~csr_wr_en_i & debug_mode_i & (csr_addr_i == 12'h7CB);
  // Answer timing, refusal and reserved-bit properties, all on the core clock.
  a_ack_after_take: assert property (take |=> csr_ack_o) else $error("ack missing.");
  a_ack_only_taken: assert property (csr_ack_o |-> $past(take))
    else $error("stray ack.");
  a_refuse_outside: assert property (take & ~debug_mode_i
    |=> csr_illegal_o && csr_rdata_o == 0) else $error("refusal wrong.");
  a_debug_accepted: assert property (take & debug_mode_i |=> !csr_illegal_o)
    else $error("access refused.");
  a_go_dead_cycle: assert property (rd_go |=> !csr_ready_o ##1 csr_ready_o)
    else $error("dead cycle wrong.");
  a_go_reads_zero: assert property (take & csr_rd_en_i & csr_addr_i == 12'h7CB
    |=> csr_rdata_o == 0) else $error("go bit read.");
  a_select_rsvd_zero: assert property (take & csr_rd_en_i & csr_addr_i == 12'h7C8
    |=> (csr_rdata_o & 32'hFECF_0003) == 0) else $error("select reserved.");
  a_check_rsvd_zero: assert property (take & csr_rd_en_i & csr_addr_i == 12'h7CA
    |=> csr_rdata_o[31:2] == 0) else $error("check reserved.");
  a_rdata_holds: assert property (!take |=> $stable(csr_rdata_o))
    else $error("rdata moved.");
endmodule : icache_diag_checker

bind icache_diag_select_data icache_diag_checker chk (.ref_clk_i, .sys_rst_i, .csr_rd_en_i,
  .csr_wr_en_i, .csr_addr_i, .csr_wdata_i, .debug_mode_i, .csr_ready_o, .csr_ack_o,
  .csr_rdata_o, .csr_illegal_o, .check_error_o);

// file: verif/csr_debugger_model.sv
`timescale 1ns/100ps

// Debugger-side CSR master; one request at a time, held until ready is seen high.
module csr_debugger_model (
  input wire logic ref_clk_i,
  input wire logic ready_i,
  input wire logic ack_i,
  input wire logic [31:0] rdata_i,
  input wire logic illegal_i,
  output logic rd_en_o,
  output logic wr_en_o,
  output logic [11:0] addr_o,
  output logic [31:0] wdata_o
);
  int stall = 0;
  // Idle lines at time zero.
  initial begin
    rd_en_o = 1'b0;
    wr_en_o = 1'b0;
    addr_o = 12'h0;
    wdata_o = 32'h0;
  end

  // Stall makes a slow master; released lines show the inverse so stale data never passes.
  task automatic xfer(input logic rd, input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic ill, output logic ok);
    int n;
    n = 0;
    repeat (stall) @(posedge ref_clk_i);
    rd_en_o <= rd;
    wr_en_o <= wr;
    addr_o <= a;
    wdata_o <= d;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (ready_i !== 1'b1 && n < 16);
    rd_en_o <= 1'b0;
    wr_en_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    @(posedge ref_clk_i);
    q = rdata_i;
    ill = illegal_i;
    ok = (n < 16) && (ack_i === 1'b1);
  endtask : xfer
endmodule : csr_debugger_model

// file: verif/icache_diag_select_data_tb.sv
`timescale 1ns/100ps
`include "icache_diag_regs.svh"

// Compares with case equality and counts every comparison.
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end

module icache_diag_select_data_tb;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic debug_mode_i = 1'b1;
  logic rd_en, wr_en, ready, ack, illegal, check_error;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  int mismatches = 0;
  int n_compared = 0;

  // Free-running 10 MHz clock.
  always #50 ref_clk_i = ~ref_clk_i;

  icache_diag_select_data DUT (.ref_clk_i, .sys_rst_i, .csr_rd_en_i(rd_en), .csr_wr_en_i(wr_en),
    .csr_addr_i(addr), .csr_wdata_i(wdata), .debug_mode_i, .csr_ready_o(ready),
    .csr_ack_o(ack), .csr_rdata_o(rdata), .csr_illegal_o(illegal), .check_error_o(check_error));
  csr_debugger_model m (.ref_clk_i, .ready_i(ready), .ack_i(ack), .rdata_i(rdata),
    .illegal_i(illegal), .rd_en_o(rd_en), .wr_en_o(wr_en), .addr_o(addr), .wdata_o(wdata));

  task automatic final_report();
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  // A hung access ends the run at once.
  task automatic acc(input logic rd, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
    logic ill, ok;
    m.xfer(rd, ~rd, a, d, q, ill, ok);
    if (!ok) begin
      mismatches++;
      final_report();
    end
    `CHK(ill, ~debug_mode_i)
  endtask : acc

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b0, a, d, q);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b1, a, 32'h0, q);
    `CHK(q, e)
  endtask : rd

  function automatic logic [31:0] sel(logic ar, logic [1:0] w, logic [5:0] ln, logic [3:0] c);
    return {7'h0, ar, 2'h0, w, 8'h0, ln, c, 2'h0};
  endfunction : sel

  task automatic t_reset();
    for (int a = 0; a < 4; a++) begin
      rd(12'h7C8 + 12'(a), 32'h0);
    end
    $display("done reset values");
  endtask : t_reset

  // A slow master here; the go write with bit zero clear must not disturb the selection.
  task automatic t_select();
    m.stall = 3;
    wr(`ICD_CSR_SELECT, 32'hFFFF_FFFF);
    rd(`ICD_CSR_SELECT, 32'h0130_FFFC);
    wr(`ICD_CSR_GO, 32'h0);
    rd(`ICD_CSR_SELECT, 32'h0130_FFFC);
    wr(`ICD_CSR_CHECK, 32'hFFFF_FFFF);
    rd(`ICD_CSR_CHECK, 32'h3);
    m.stall = 0;
    $display("done select");
  endtask : t_select

  // Every way and chunk of one line gets its own value, written first and read back after.
  task automatic t_data();
    logic [31:0] d;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 64; i++) begin
        d = 32'h1357_9BDF * (i + 1);
        wr(`ICD_CSR_SELECT, sel(1'b0, i[5:4], 6'h2A, i[3:0]));
        if (p == 0) begin
          wr(`ICD_CSR_DATA, d);
          wr(`ICD_CSR_CHECK, {30'h0, ^d[31:16], ^d[15:0]});
          wr(`ICD_CSR_GO, 32'h1);
        end else begin
          rd(`ICD_CSR_GO, 32'h0);
          rd(`ICD_CSR_DATA, d);
          rd(`ICD_CSR_CHECK, {30'h0, ^d[31:16], ^d[15:0]});
          `CHK(check_error, 1'b0)
        end
      end
    end
    $display("done data array");
  endtask : t_data

  // A wrong low check bit is stored as given and flagged on the next trigger read.
  task automatic t_inject();
    wr(`ICD_CSR_SELECT, sel(1'b0, 2'h1, 6'h05, 4'h7));
    wr(`ICD_CSR_DATA, 32'h1);
    wr(`ICD_CSR_CHECK, 32'h0);
    wr(`ICD_CSR_GO, 32'h1);
    rd(`ICD_CSR_GO, 32'h0);
    rd(`ICD_CSR_CHECK, 32'h0);
    `CHK(check_error, 1'b1)
    $display("done injection");
  endtask : t_inject

  // Tags are read back with other chunk bits; the last LRU write is seen from every way.
  task automatic t_tag();
    logic [19:0] t;
    for (int p = 0; p < 2; p++) begin
      for (int w = 0; w < 4; w++) begin
        t = 20'h8_1234 ^ 20'(w);
        wr(`ICD_CSR_SELECT, sel(1'b1, w[1:0], 6'h11, p[0] ? 4'hF : 4'h0));
        if (p == 0) begin
          wr(`ICD_CSR_DATA, {t, 5'h0, 3'(w + 2), 3'h0, w[0]});
          wr(`ICD_CSR_CHECK, {31'h0, ^t});
          wr(`ICD_CSR_GO, 32'h1);
        end else begin
          rd(`ICD_CSR_GO, 32'h0);
          rd(`ICD_CSR_DATA, {t, 5'h0, 3'h5, 3'h0, w[0]});
          rd(`ICD_CSR_CHECK, {31'h0, ^t});
          `CHK(check_error, 1'b0)
        end
      end
    end
    $display("done tag array");
  endtask : t_tag

  task automatic t_illegal();
    wr(`ICD_CSR_SELECT, sel(1'b0, 2'h3, 6'h01, 4'h2));
    debug_mode_i <= 1'b0;
    wr(`ICD_CSR_SELECT, 32'hFFFF_FFFF);
    rd(`ICD_CSR_SELECT, 32'h0);
    debug_mode_i <= 1'b1;
    rd(`ICD_CSR_SELECT, sel(1'b0, 2'h3, 6'h01, 4'h2));
    $display("done outside debug");
  endtask : t_illegal

  // Main sequence, ending with a second reset over non-zero registers.
  initial begin
    repeat (8) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    t_reset();
    t_select();
    t_data();
    t_inject();
    t_tag();
    t_illegal();
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    t_reset();
    final_report();
  end
endmodule : icache_diag_select_data_tb
